// File: rtl/sdc_pkg.sv
// Constants, types and register map of the serdes control register bank.
// Assumes the management frame engine and the bank share one clock.
package sdc_pkg;

  // Management frame layout
  localparam int          PREAMBLE_ONES = 32;
  localparam int          HEADER_BITS   = 14;
  localparam int          DATA_BITS     = 16;
  localparam logic [1:0]  START_CODE    = 2'h0;
  localparam logic [1:0]  OP_ADDRESS    = 2'h0;
  localparam logic [1:0]  OP_WRITE      = 2'h1;
  localparam logic [1:0]  OP_READ_INC   = 2'h2;
  localparam logic [1:0]  OP_READ       = 2'h3;
  localparam logic [4:0]  DEVICE_ADDR   = 5'h1E;

  // Register addresses
  localparam logic [15:0] ADDR_RESERVED   = 16'h0000;
  localparam logic [15:0] ADDR_POWER      = 16'h0001;
  localparam logic [15:0] ADDR_ID_LOW     = 16'h0002;
  localparam logic [15:0] ADDR_ID_HIGH    = 16'h0003;
  localparam logic [15:0] ADDR_SOFT_RESET = 16'h0004;
  localparam logic [15:0] ADDR_RX_EQUALIZER_SETTING      = 16'h0005;
  localparam logic [15:0] ADDR_TX_EMPHASIS_SETTING      = 16'h0006;
  localparam logic [15:0] ADDR_LOOPBACK   = 16'h0007;
  localparam logic [15:0] ADDR_MARKER     = 16'h0008;
  localparam logic [15:0] ADDR_SELF_TEST  = 16'h0009;
  localparam logic [15:0] ADDR_ID_LOW_M   = 16'h000E;
  localparam logic [15:0] ADDR_ID_HIGH_M  = 16'h000F;

  // Reset values
  localparam logic [15:0] RST_RESERVED   = 16'h0000;
  localparam logic [15:0] RST_POWER      = 16'hFFFF;
  localparam logic [15:0] RST_SOFT_RESET = 16'hFFFF;
  localparam logic [15:0] RST_RX_EQUALIZER_SETTING      = 16'h0000;
  localparam logic [15:0] RST_TX_EMPHASIS_SETTING      = 16'h2000;
  localparam logic [15:0] RST_LOOPBACK   = 16'h0000;
  localparam logic [15:0] RST_MARKER     = 16'h8000;
  localparam logic [15:0] RST_SELF_TEST  = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ  = 16'h0000;

  // Field positions
  localparam int RX_BIT       = 8;
  localparam int TX_BIT       = 0;
  localparam int BYPASS_BIT   = 15;
  localparam int FRAME_MSB    = 15;
  localparam int FRAME_LSB    = 8;
  localparam int PAR_OUT_BIT  = 10;
  localparam int CHECK_EN_BIT = 9;
  localparam int GEN_EN_BIT   = 8;
  localparam int RX_PAT_LSB   = 4;
  localparam int TX_PAT_LSB   = 0;

  // Soft-reset hold time in reference clock cycles
  localparam int SOFT_RESET_HOLD = 4;

  typedef enum logic [2:0] {
    SDC_LOOP_NORMAL, SDC_LOOP_LINE, SDC_LOOP_LOCAL,
    SDC_LOOP_SPECIAL_LOCAL, SDC_LOOP_SPECIAL_LINE, SDC_LOOP_DIGITAL
  } sdc_loop_t;

  typedef enum logic [1:0] {
    SDC_PAT_JITTER, SDC_PAT_PRWS, SDC_PAT_RESERVED
  } sdc_pattern_t;

  // Control word driven to the serdes datapath
  typedef struct packed {
    logic         tx_low_power;
    logic         rx_low_power;
    logic         tx_soft_reset;
    logic         rx_soft_reset;
    logic         frame_loss_bypass;
    logic [1:0]   rx_equalizer_setting;
    logic [1:0]   tx_emphasis_setting;
    logic [7:0]   hyperframe_size;
    sdc_loop_t    loopback;
    logic         rx_parallel_out_en;
    logic         rx_check_en;
    logic         tx_gen_en;
    sdc_pattern_t rx_check_pattern_sel;
    sdc_pattern_t tx_gen_pattern_sel;
  } sdc_ctl_t;

endpackage : sdc_pkg

// File: rtl/sdc_regs.sv
// Low control register bank of a multi-rate serdes with its management
// serial slave. Assumes mdc is far slower than mclk (at most mclk/8).
`timescale 1ns/10ps
module sdc_regs #(
  parameter logic [15:0] ID_LOW  = 16'hA5C3, // Arbitrary identity value
  parameter logic [15:0] ID_HIGH = 16'h3C51, // Arbitrary identity value
  parameter int          HOLD    = sdc_pkg::SOFT_RESET_HOLD
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       mdc_pin,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe,
  input  wire logic [4:0] phy_addr_pins,
  input  wire logic       tx_power_pin,
  input  wire logic       rx_power_pin,
  input  wire logic [1:0] equalizer_strap_pins,
  input  wire logic [1:0] emphasis_strap_pins,
  output sdc_pkg::sdc_ctl_t ctl
);

  typedef enum logic [1:0] {
    SDC_FR_PREAMBLE, SDC_FR_HEADER, SDC_FR_TURN, SDC_FR_DATA
  } sdc_frame_t;

  // Loopback decode, priority per field value
  function automatic sdc_pkg::sdc_loop_t loop_decode(input logic [3:0] v);
    if (v[0])
      return sdc_pkg::SDC_LOOP_LOCAL;
    else if (v[1])
      return sdc_pkg::SDC_LOOP_LINE;
    else
      unique case (v[3:2])
        2'h2:    return sdc_pkg::SDC_LOOP_SPECIAL_LOCAL;
        2'h1:    return sdc_pkg::SDC_LOOP_SPECIAL_LINE;
        2'h3:    return sdc_pkg::SDC_LOOP_DIGITAL;
        default: return sdc_pkg::SDC_LOOP_NORMAL;
      endcase
  endfunction : loop_decode

  // Pattern select decode shared by both directions
  function automatic sdc_pkg::sdc_pattern_t pat_decode(input logic [1:0] v);
    unique case (v)
      2'h1:    return sdc_pkg::SDC_PAT_PRWS;
      2'h2:    return sdc_pkg::SDC_PAT_RESERVED;
      default: return sdc_pkg::SDC_PAT_JITTER;
    endcase
  endfunction : pat_decode

  // Pin synchronisers
  logic [1:0] mdc_sync;
  logic [1:0] mdio_sync;
  logic       mdc_last;
  logic [4:0] phy_sync1;
  logic [4:0] phy_sync2;
  logic [1:0] pwr_sync1;
  logic [1:0] pwr_sync2;
  logic [3:0] strap_sync1;
  logic [3:0] strap_sync2;

  // Frame engine state
  sdc_frame_t       state;
  logic [5:0]       ones;
  logic [3:0]       bitcnt;
  logic [13:0]      hdr;
  logic [15:0]      shreg;
  logic [1:0]       op;
  logic             hit;
  logic             sending;
  logic [15:0]      rd_shift;
  logic             do_write;
  logic             do_addr;
  logic             do_inc;
  logic [4:0]       phy_addr;

  // Register state
  logic [15:0]      addr;
  logic             rx_power_n;
  logic             tx_power_n;
  logic [15:0]      eq_reg;
  logic [15:0]      de_reg;
  logic [15:0]      loop_reg;
  logic             par_out_en;
  logic [1:0]       bist_en;
  logic [1:0]       rx_pat;
  logic [1:0]       tx_pat;
  logic [1:0]       sr_start;
  logic [1:0]       sr_held;
  logic [15:0]      rdata;
  logic [13:0]      next_hdr;
  logic             mdc_rise;
  logic             mdio_bit;
  sdc_pkg::sdc_ctl_t next_ctl;

  // Two-flop synchronisers; the first stage feeds only the second
  always_ff @(posedge mclk) begin
    mdc_sync    <= {mdc_sync[0], mdc_pin};
    mdio_sync   <= {mdio_sync[0], mdio_in};
    mdc_last    <= mdc_sync[1];
    phy_sync1   <= phy_addr_pins;
    phy_sync2   <= phy_sync1;
    pwr_sync1   <= {rx_power_pin, tx_power_pin};
    pwr_sync2   <= pwr_sync1;
    strap_sync1 <= {equalizer_strap_pins, emphasis_strap_pins};
    strap_sync2 <= strap_sync1;
  end

  assign mdc_rise = mdc_sync[1] & ~mdc_last;
  assign mdio_bit = mdio_sync[1];
  assign next_hdr = {hdr[12:0], mdio_bit};

  // Station address strap caught while reset is held
  always_ff @(posedge mclk) begin
    if (rst)
      phy_addr <= phy_sync2;
  end

  // Frame receiver: preamble, header, turnaround, 16-bit data
  always_ff @(posedge mclk) begin
    do_write <= 1'b0;
    do_addr  <= 1'b0;
    do_inc   <= 1'b0;
    if (rst) begin
      state  <= SDC_FR_PREAMBLE;
      ones   <= '0;
      bitcnt <= '0;
      hdr    <= '0;
      shreg  <= '0;
      op     <= sdc_pkg::OP_READ;
      hit    <= 1'b0;
    end else if (mdc_rise) begin
      unique case (state)
        SDC_FR_PREAMBLE: begin
          if (mdio_bit) begin
            if (ones < 6'(sdc_pkg::PREAMBLE_ONES))
              ones <= ones + 6'd1;
          end else begin
            ones <= '0;
            if (ones == 6'(sdc_pkg::PREAMBLE_ONES)) begin
              state  <= SDC_FR_HEADER;
              hdr    <= '0;
              bitcnt <= 4'd1;
            end
          end
        end
        SDC_FR_HEADER: begin
          hdr    <= next_hdr;
          bitcnt <= bitcnt + 4'd1;
          if (bitcnt == 4'(sdc_pkg::HEADER_BITS - 1)) begin
            bitcnt <= '0;
            op     <= next_hdr[11:10];
            hit    <= (next_hdr[9:5] == phy_addr);
            if (next_hdr[13:12] == sdc_pkg::START_CODE)
              state <= SDC_FR_TURN;
            else
              state <= SDC_FR_PREAMBLE;
          end
        end
        SDC_FR_TURN: begin
          bitcnt <= bitcnt + 4'd1;
          if (bitcnt == 4'd1) begin
            state  <= SDC_FR_DATA;
            bitcnt <= '0;
          end
        end
        SDC_FR_DATA: begin
          shreg  <= {shreg[14:0], mdio_bit};  // Bit 15 first
          bitcnt <= bitcnt + 4'd1;
          if (bitcnt == 4'(sdc_pkg::DATA_BITS - 1)) begin
            state    <= SDC_FR_PREAMBLE;
            bitcnt   <= '0;
            do_write <= hit & (op == sdc_pkg::OP_WRITE);
            do_addr  <= hit & (op == sdc_pkg::OP_ADDRESS);
            do_inc   <= hit & (op == sdc_pkg::OP_READ_INC);
          end
        end
      endcase
    end
  end

  // Read multiplexer; unmapped register addresses answer zero
  always_comb begin
    unique case (addr)
      sdc_pkg::ADDR_RESERVED:   rdata = sdc_pkg::RST_RESERVED;
      sdc_pkg::ADDR_POWER: begin
        rdata = sdc_pkg::RST_POWER;
        rdata[sdc_pkg::RX_BIT] = rx_power_n;
        rdata[sdc_pkg::TX_BIT] = tx_power_n;
      end
      sdc_pkg::ADDR_ID_LOW,
      sdc_pkg::ADDR_ID_LOW_M:   rdata = ID_LOW;
      sdc_pkg::ADDR_ID_HIGH,
      sdc_pkg::ADDR_ID_HIGH_M:  rdata = ID_HIGH;
      sdc_pkg::ADDR_SOFT_RESET: begin
        rdata = sdc_pkg::RST_SOFT_RESET;
        rdata[sdc_pkg::RX_BIT] = ~sr_held[1];
        rdata[sdc_pkg::TX_BIT] = ~sr_held[0];
      end
      sdc_pkg::ADDR_RX_EQUALIZER_SETTING:      rdata = eq_reg;
      sdc_pkg::ADDR_TX_EMPHASIS_SETTING:      rdata = de_reg;
      sdc_pkg::ADDR_LOOPBACK:   rdata = loop_reg;
      sdc_pkg::ADDR_MARKER:     rdata = sdc_pkg::RST_MARKER;
      sdc_pkg::ADDR_SELF_TEST: begin
        rdata = sdc_pkg::RST_SELF_TEST;
        rdata[sdc_pkg::PAR_OUT_BIT] = par_out_en;
        rdata[sdc_pkg::CHECK_EN_BIT -: 2] = bist_en;
        rdata[sdc_pkg::RX_PAT_LSB +: 2] = rx_pat;
        rdata[sdc_pkg::TX_PAT_LSB +: 2] = tx_pat;
      end
      default:                  rdata = sdc_pkg::UNMAPPED_READ;
    endcase
  end

  // Read answer: release on first turnaround bit, zero on second
  always_ff @(posedge mclk) begin
    if (rst) begin
      sending  <= 1'b0;
      rd_shift <= '0;
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
    end else if (mdc_rise) begin
      unique case (state)
        SDC_FR_HEADER: begin
          if (bitcnt == 4'(sdc_pkg::HEADER_BITS - 1)) begin
            sending  <= (next_hdr[13:12] == sdc_pkg::START_CODE) &
                        (next_hdr[9:5] == phy_addr) & next_hdr[11];
            rd_shift <= (next_hdr[4:0] == sdc_pkg::DEVICE_ADDR) ?
                        rdata : sdc_pkg::UNMAPPED_READ;
          end
        end
        SDC_FR_TURN: begin
          if (sending && bitcnt == 4'd0) begin
            mdio_oe  <= 1'b1;
            mdio_out <= 1'b0;
          end else if (sending) begin
            mdio_out <= rd_shift[15];
            rd_shift <= {rd_shift[14:0], 1'b0};
          end
        end
        SDC_FR_DATA: begin
          if (sending && bitcnt == 4'(sdc_pkg::DATA_BITS - 1)) begin
            mdio_oe  <= 1'b0;
            mdio_out <= 1'b0;
            sending  <= 1'b0;
          end else if (sending) begin
            mdio_out <= rd_shift[15];
            rd_shift <= {rd_shift[14:0], 1'b0};
          end
        end
        default: begin
          mdio_oe <= 1'b0;
          sending <= 1'b0;
        end
      endcase
    end
  end

  // Address pointer: set by address frames, stepped after read-increment
  always_ff @(posedge mclk) begin
    if (rst)
      addr <= '0;
    else if (do_addr)
      addr <= shreg;
    else if (do_inc)
      addr <= addr + 16'h0001;
  end

  // Writable registers; identity and marker words ignore writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_power_n <= sdc_pkg::RST_POWER[sdc_pkg::RX_BIT];
      tx_power_n <= sdc_pkg::RST_POWER[sdc_pkg::TX_BIT];
      eq_reg     <= sdc_pkg::RST_RX_EQUALIZER_SETTING;
      de_reg     <= sdc_pkg::RST_TX_EMPHASIS_SETTING;
      loop_reg   <= sdc_pkg::RST_LOOPBACK;
      par_out_en <= sdc_pkg::RST_SELF_TEST[sdc_pkg::PAR_OUT_BIT];
      bist_en    <= sdc_pkg::RST_SELF_TEST[sdc_pkg::CHECK_EN_BIT -: 2];
      rx_pat     <= sdc_pkg::RST_SELF_TEST[sdc_pkg::RX_PAT_LSB +: 2];
      tx_pat     <= sdc_pkg::RST_SELF_TEST[sdc_pkg::TX_PAT_LSB +: 2];
    end else if (do_write) begin
      unique case (addr)
        sdc_pkg::ADDR_POWER: begin
          rx_power_n <= shreg[sdc_pkg::RX_BIT];
          tx_power_n <= shreg[sdc_pkg::TX_BIT];
        end
        sdc_pkg::ADDR_RX_EQUALIZER_SETTING:    eq_reg   <= shreg;
        sdc_pkg::ADDR_TX_EMPHASIS_SETTING:    de_reg   <= shreg;
        sdc_pkg::ADDR_LOOPBACK: loop_reg <= shreg;
        sdc_pkg::ADDR_SELF_TEST: begin
          par_out_en <= shreg[sdc_pkg::PAR_OUT_BIT];
          bist_en <= shreg[sdc_pkg::CHECK_EN_BIT -: 2];
          rx_pat  <= shreg[sdc_pkg::RX_PAT_LSB +: 2];
          tx_pat  <= shreg[sdc_pkg::TX_PAT_LSB +: 2];
        end
        default: ;
      endcase
    end
  end

  // Writing zero to a reset bit starts its channel (index 1 rx, 0 tx)
  assign sr_start[1] = do_write & (addr == sdc_pkg::ADDR_SOFT_RESET) &
                       ~shreg[sdc_pkg::RX_BIT];
  assign sr_start[0] = do_write & (addr == sdc_pkg::ADDR_SOFT_RESET) &
                       ~shreg[sdc_pkg::TX_BIT];

  for (genvar i = 0; i < 2; i++) begin : g_soft_reset
    sdc_soft_reset #(
      .HOLD_CYCLES (HOLD)
    ) u_soft_reset (
      .mclk  (mclk),
      .rst   (rst),
      .start (sr_start[i]),
      .held  (sr_held[i])
    );
  end

  // Control word assembly; nonzero straps override software settings
  always_comb begin
    next_ctl = '0;
    next_ctl.rx_low_power  = ~rx_power_n | ~pwr_sync2[1];
    next_ctl.tx_low_power  = ~tx_power_n | ~pwr_sync2[0];
    next_ctl.rx_soft_reset = sr_held[1];
    next_ctl.tx_soft_reset = sr_held[0];
    next_ctl.frame_loss_bypass = eq_reg[sdc_pkg::BYPASS_BIT];
    next_ctl.rx_equalizer_setting = (strap_sync2[3:2] == 2'h0) ?
                                    eq_reg[1:0] : strap_sync2[3:2];
    next_ctl.tx_emphasis_setting  = (strap_sync2[1:0] == 2'h0) ?
                                    de_reg[1:0] : strap_sync2[1:0];
    next_ctl.hyperframe_size =
      de_reg[sdc_pkg::FRAME_MSB:sdc_pkg::FRAME_LSB];
    next_ctl.loopback = loop_decode(loop_reg[3:0]);
    next_ctl.rx_parallel_out_en = par_out_en & bist_en[1];
    next_ctl.rx_check_en = bist_en[1];
    next_ctl.tx_gen_en   = bist_en[0];
    next_ctl.rx_check_pattern_sel = pat_decode(rx_pat);
    next_ctl.tx_gen_pattern_sel   = pat_decode(tx_pat);
  end

  // Registered control outputs
  always_ff @(posedge mclk) begin
    if (rst)
      ctl <= '0;
    else
      ctl <= next_ctl;
  end

endmodule : sdc_regs

// File: rtl/sdc_soft_reset.sv
// Self-restoring soft-reset channel: holds reset for a fixed cycle count.
// Assumes start is a one-cycle pulse on mclk.
`timescale 1ns/10ps
module sdc_soft_reset #(
  parameter int HOLD_CYCLES = sdc_pkg::SOFT_RESET_HOLD
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic start,
  output logic      held
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);

  if (HOLD_CYCLES < 1) begin : g_bad_hold
    $error("sdc_soft_reset: HOLD_CYCLES must be at least 1");
  end

  logic [CW-1:0] remaining;

  // Countdown; a new start restarts it, so a start is never lost
  always_ff @(posedge mclk) begin
    if (rst) begin
      remaining <= '0;
      held      <= 1'b0;
    end else if (start) begin
      remaining <= CW'(HOLD_CYCLES);
      held      <= 1'b1;
    end else if (remaining > CW'(1)) begin
      remaining <= remaining - CW'(1); // Halts if mclk stops
    end else begin
      remaining <= '0;
      held      <= 1'b0;               // Bit returns to one
    end
  end

endmodule : sdc_soft_reset

// File: testbench/sdc_regs_assertions.sv
// Port checks for the serdes control register bank.
// Assumes one mclk domain and a synchronous active-high rst.
`timescale 1ns/10ps
module sdc_regs_checker #(
  parameter int HOLD = 4
) (
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              mdc_pin,
  input wire logic              mdio_out,
  input wire logic              mdio_oe,
  input wire logic              tx_power_pin,
  input wire logic              rx_power_pin,
  input wire logic [1:0]        equalizer_strap_pins,
  input wire logic [1:0]        emphasis_strap_pins,
  input wire sdc_pkg::sdc_ctl_t ctl
);
  logic mdc_q;
  int   oe_rises;
  int   rx_hi;
  int   tx_hi;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Management clock rises counted while the data pin is driven
  always_ff @(posedge mclk) begin
    mdc_q <= mdc_pin;
    if (rst || !mdio_oe) oe_rises <= 0;
    else if (mdc_pin && !mdc_q) oe_rises <= oe_rises + 1;
  end

  // Length of each soft-reset pulse
  always_ff @(posedge mclk) begin
    rx_hi <= (rst || !ctl.rx_soft_reset) ? 0 : rx_hi + 1;
    tx_hi <= (rst || !ctl.tx_soft_reset) ? 0 : tx_hi + 1;
  end

  sequence s_rx_off;
    (!rx_power_pin && !rst) [*6];
  endsequence
  sequence s_tx_off;
    (!tx_power_pin && !rst) [*6];
  endsequence

  a_turn_zero: assert property ($rose(mdio_oe) |-> !mdio_out)
    else $error("turnaround bit not low");
  a_read_span: assert property ($fell(mdio_oe) |-> oe_rises == 17)
    else $error("read answer length wrong");
  a_rx_hold: assert property (
    $fell(ctl.rx_soft_reset) |-> rx_hi == HOLD)
    else $error("rx soft reset length wrong");
  a_tx_hold: assert property (
    $fell(ctl.tx_soft_reset) |-> tx_hi == HOLD)
    else $error("tx soft reset length wrong");
  a_rx_pin_off: assert property (s_rx_off |-> ctl.rx_low_power)
    else $error("rx power pin ignored");
  a_tx_pin_off: assert property (s_tx_off |-> ctl.tx_low_power)
    else $error("tx power pin ignored");
  a_eq_strap: assert property (($stable(equalizer_strap_pins)
    && equalizer_strap_pins != 2'h0) [*6]
    |-> ctl.rx_equalizer_setting == equalizer_strap_pins)
    else $error("equalizer strap ignored");
  a_pe_strap: assert property (($stable(emphasis_strap_pins)
    && emphasis_strap_pins != 2'h0) [*6]
    |-> ctl.tx_emphasis_setting == emphasis_strap_pins)
    else $error("emphasis strap ignored");
  a_rx_parallel_out_gate: assert property (
    ctl.rx_parallel_out_en |-> ctl.rx_check_en)
    else $error("parallel out without self-test");
  a_frame_init: assert property ($fell(rst)
    |-> ##[1:3] ctl.hyperframe_size == 8'h20)
    else $error("hyperframe size reset wrong");
endmodule : sdc_regs_checker

bind sdc_regs sdc_regs_checker #(.HOLD(HOLD)) u_chk (
  .mclk                 (mclk),
  .rst                  (rst),
  .mdc_pin              (mdc_pin),
  .mdio_out             (mdio_out),
  .mdio_oe              (mdio_oe),
  .tx_power_pin         (tx_power_pin),
  .rx_power_pin         (rx_power_pin),
  .equalizer_strap_pins (equalizer_strap_pins),
  .emphasis_strap_pins  (emphasis_strap_pins),
  .ctl                  (ctl)
);

// File: testbench/sdc_station.sv
// Management station model: frames, register writes and reads.
// Assumes a pulled-up data line resolved by the bench.
`timescale 1ns/10ps
module sdc_station #(
  parameter logic [4:0] PHY = 5'h05
) (
  input  wire logic mclk,
  input  wire logic line,
  output logic      mdc,
  output logic      st_oe,
  output logic      st_do
);
  // Idle: clock parked low, line released
  initial begin
    mdc   = 1'b0;
    st_oe = 1'b0;
    st_do = 1'b0;
  end

  // One bit: set after the fall, sample at the rise (mclk/8)
  task automatic bit_cyc(input logic drv, input logic b, output logic s);
    st_oe = drv;
    st_do = b;
    repeat (4) @(negedge mclk);
    mdc = 1'b1;
    s   = line;
    repeat (4) @(negedge mclk);
    mdc = 1'b0;
  endtask : bit_cyc

  // Whole frame, fields sent most significant bit first
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] dev, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [13:0] hdr;
    logic        s;
    hdr = {sdc_pkg::START_CODE, op, phy, dev};
    for (int i = 0; i < sdc_pkg::PREAMBLE_ONES; i++) bit_cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
    bit_cyc(!op[1], 1'b1, s);
    bit_cyc(!op[1], 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(!op[1], wd[i], s);
      rd[i] = s;
    end
    st_oe = 1'b0;
    repeat (8) @(negedge mclk);
  endtask : frame

  // Register write: address frame then write frame
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] q;
    frame(sdc_pkg::OP_ADDRESS, PHY, sdc_pkg::DEVICE_ADDR, a, q);
    frame(sdc_pkg::OP_WRITE, PHY, sdc_pkg::DEVICE_ADDR, d, q);
  endtask : wr

  // Register read: address frame then read frame
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    logic [15:0] q;
    frame(sdc_pkg::OP_ADDRESS, PHY, sdc_pkg::DEVICE_ADDR, a, q);
    frame(sdc_pkg::OP_READ, PHY, sdc_pkg::DEVICE_ADDR, 16'h0000, d);
  endtask : rd
endmodule : sdc_station

// File: testbench/tb_top.sv
// Self-checking bench for the serdes control register bank.
// Assumes the station model owns the management pins.
`timescale 1ns/10ps
module tb_top;
  localparam int          HT  = 3;
  localparam logic [15:0] IDL = 16'h1357; // Arbitrary identity value
  localparam logic [15:0] IDH = 16'h2468; // Arbitrary identity value
  logic              mclk, rst, mdc, st_oe, st_do, m_out, m_oe, line;
  logic              txp, rxp;
  logic [1:0]        eqp, pep;
  logic [15:0]       rdv, pwr;
  logic [2:0]        test_en;
  sdc_pkg::sdc_ctl_t ctl;
  int                num_errors, checks, hi [2];

  // Pulled-up data line, power state view
  assign line = m_oe ? m_out : (st_oe ? st_do : 1'b1);
  assign pwr  = {14'h0, ctl.tx_low_power, ctl.rx_low_power};
  assign test_en = {ctl.rx_parallel_out_en, ctl.rx_check_en, ctl.tx_gen_en};

  sdc_regs #(.ID_LOW(IDL), .ID_HIGH(IDH), .HOLD(HT)) dut (
    .mclk(mclk), .rst(rst), .mdc_pin(mdc), .mdio_in(line),
    .mdio_out(m_out), .mdio_oe(m_oe), .phy_addr_pins(5'h05),
    .tx_power_pin(txp), .rx_power_pin(rxp), .equalizer_strap_pins(eqp),
    .emphasis_strap_pins(pep), .ctl(ctl)
  );
  sdc_station #(.PHY(5'h05)) st (
    .mclk(mclk), .line(line), .mdc(mdc), .st_oe(st_oe), .st_do(st_do)
  );

  // Clock and soft-reset pulse counters
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (ctl.rx_soft_reset === 1'b1) hi[0] = hi[0] + 1;
    if (ctl.tx_soft_reset === 1'b1) hi[1] = hi[1] + 1;
  end

  task automatic compare(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : compare

  task automatic rd_cmp(input logic [15:0] a, input logic [15:0] exp);
    st.rd(a, rdv);
    compare(rdv, exp);
  endtask : rd_cmp

  task automatic conclude();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  // Expected loopback mode and pattern decodes
  function automatic sdc_pkg::sdc_loop_t exp_loop(input logic [3:0] v);
    if (v[0]) return sdc_pkg::SDC_LOOP_LOCAL;
    if (v[1]) return sdc_pkg::SDC_LOOP_LINE;
    if (v[3:2] == 2'h2) return sdc_pkg::SDC_LOOP_SPECIAL_LOCAL;
    if (v[3:2] == 2'h1) return sdc_pkg::SDC_LOOP_SPECIAL_LINE;
    if (v[3:2] == 2'h3) return sdc_pkg::SDC_LOOP_DIGITAL;
    return sdc_pkg::SDC_LOOP_NORMAL;
  endfunction : exp_loop
  function automatic sdc_pkg::sdc_pattern_t exp_pat(input logic [1:0] v);
    if (v == 2'h1) return sdc_pkg::SDC_PAT_PRWS;
    if (v == 2'h2) return sdc_pkg::SDC_PAT_RESERVED;
    return sdc_pkg::SDC_PAT_JITTER;
  endfunction : exp_pat

  // Watchdog
  initial begin
    repeat (90000) @(posedge mclk);
    num_errors++;
    conclude();
  end

  // Main sequence
  initial begin
    {rst, txp, rxp, eqp, pep} = 7'h70;
    num_errors = 0;
    checks = 0;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    repeat (6) @(negedge mclk);
    rd_cmp(16'h0001, 16'hFFFF);
    rd_cmp(16'h0004, 16'hFFFF);
    rd_cmp(16'h0005, 16'h0000);
    rd_cmp(16'h0006, 16'h2000);
    rd_cmp(16'h0007, 16'h0000);
    rd_cmp(16'h0009, 16'h0000);
    compare(pwr, 16'h0000);
    rd_cmp(16'h000E, IDL);
    rd_cmp(16'h000F, IDH);
    st.frame(sdc_pkg::OP_ADDRESS, 5'h05, 5'h1E, 16'h0002, rdv);
    st.frame(sdc_pkg::OP_READ_INC, 5'h05, 5'h1E, 16'h0000, rdv);
    compare(rdv, IDL);
    st.frame(sdc_pkg::OP_READ, 5'h05, 5'h1E, 16'h0000, rdv);
    compare(rdv, IDH);
    st.wr(16'h0002, 16'h0000);
    rd_cmp(16'h0002, IDL);
    st.wr(16'h0008, 16'h0000);
    st.rd(16'h0008, rdv);
    compare(rdv & 16'hC000, 16'h8000);
    rd_cmp(16'h0020, 16'h0000);
    st.frame(sdc_pkg::OP_READ, 5'h04, 5'h1E, 16'h0000, rdv);
    compare(rdv, 16'hFFFF);
    st.frame(sdc_pkg::OP_READ, 5'h05, 5'h00, 16'h0000, rdv);
    compare(rdv, 16'h0000);
    st.wr(16'h0001, 16'hFEFF);
    compare(pwr, 16'h0001);
    st.wr(16'h0001, 16'hFFFE);
    compare(pwr, 16'h0002);
    st.wr(16'h0001, 16'hFFFF);
    compare(pwr, 16'h0000);
    {txp, rxp} = 2'h0;
    repeat (8) @(negedge mclk);
    compare(pwr, 16'h0003);
    {txp, rxp} = 2'h3;
    for (int j = 0; j < 2; j++) begin
      hi[0] = 0;
      hi[1] = 0;
      st.wr(16'h0004, j ? 16'hFFFE : 16'hFEFF);
      rd_cmp(16'h0004, 16'hFFFF);
      compare(16'(hi[j]), 16'(HT));
      compare(16'(hi[1-j]), 16'h0000);
    end
    st.wr(16'h0005, 16'h8002);
    rd_cmp(16'h0005, 16'h8002);
    compare(16'({ctl.frame_loss_bypass,
                 ctl.rx_equalizer_setting}), 16'h6);
    eqp = 2'h1;
    st.wr(16'h0006, 16'h5503);
    compare(16'(ctl.rx_equalizer_setting), 16'h1);
    rd_cmp(16'h0006, 16'h5503);
    compare(16'({ctl.hyperframe_size,
                 ctl.tx_emphasis_setting}), 16'h157);
    pep = 2'h2;
    repeat (8) @(negedge mclk);
    compare(16'(ctl.tx_emphasis_setting), 16'h2);
    for (int v = 0; v < 16; v++) begin
      st.wr(16'h0007, 16'(v));
      compare(16'(ctl.loopback), 16'(exp_loop(4'(v))));
    end
    st.wr(16'h0009, 16'h0400);
    compare(16'(test_en), 16'h0);
    st.wr(16'h0009, 16'h0600);
    compare(16'(test_en), 16'h6);
    st.wr(16'h0009, 16'h0100);
    compare(16'(test_en), 16'h1);
    for (int p = 0; p < 4; p++) begin
      st.wr(16'h0009, 16'(p * 16 + 3 - p));
      compare(16'({ctl.rx_check_pattern_sel, ctl.tx_gen_pattern_sel}),
              16'({exp_pat(2'(p)), exp_pat(2'(3 - p))}));
      rd_cmp(16'h0009, 16'(p * 16 + 3 - p));
    end
    conclude();
  end
endmodule : tb_top
